// ---- hw/pciu_regs.svh ----
// Register offsets, field positions and reset values of the pin change interrupt unit.
`ifndef PCIU_REGS_SVH
`define PCIU_REGS_SVH

`define PCIU_ADDR_W 8
`define PCIU_OFS_FLAGS 8'h3B
`define PCIU_OFS_ENABLES 8'h68
`define PCIU_OFS_SENSE 8'h69
`define PCIU_OFS_MASK0 8'h6B
`define PCIU_OFS_MASK1 8'h6C
`define PCIU_OFS_MASK2 8'h6D
`define PCIU_OFS_EXT_FLAGS 8'h3C
`define PCIU_OFS_EXT_ENABLE 8'h3D
`define PCIU_GROUP_BITS 3'h7
`define PCIU_MASK1_BITS 8'h7F
`define PCIU_SENSE_BITS 2'h3
`define PCIU_RESET_BYTE 8'h00
`define PCIU_ZERO_BYTE 8'h00
`define PCIU_BIT_EXT0 0
`define PCIU_SENSE_LOW 2'h0
`define PCIU_SENSE_ANY 2'h1
`define PCIU_SENSE_FALL 2'h2
`define PCIU_SENSE_RISE 2'h3

`endif

// ---- hw/pciu_pkg.sv ----
// Types shared by the pin change interrupt unit.
package pciu_pkg;
    typedef logic [7:0] pciu_byte_t;
    typedef logic [2:0] pciu_group_t;
    typedef logic [1:0] pciu_sense_t;
endpackage : pciu_pkg

// ---- hw/pciu_core.sv ----
// Pin change and external interrupt zero logic with its register port.
//
// Function
// - Set ext0 pending on recognised request.
// - Ext0 requests only with global and enable.
// - Ext0 pending cleared by acknowledge or write-one.
// - Ext0 pending held zero under low sensing.
// - Enable and flag bits 7..3 read zero.
// - Group two enabled by enable bit 2.
// - Group one enabled by enable bit 1.
// - Group zero enabled by enable bit 0.
// - Change on high inputs sets flag two.
// - Change on mid inputs sets flag one.
// - Change on low inputs sets flag zero.
// - Group request needs global and group enable.
// - Group flags cleared by acknowledge or write-one.
// - Each group has its own request vector.
// - Group two mask bits gate each pin.
// - Group one mask uses bits 6..0.
// - Group one mask bit 7 reads zero.
// - Group zero mask bits gate each pin.
// - Change detected on all 23 inputs.
// - Inputs sensed regardless of pin direction.
// - Sense value 00 selects low level.
`timescale 1ns/1ps
`default_nettype none
`include "pciu_regs.svh"

module pciu_core (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port.
    input wire logic [`PCIU_ADDR_W-1:0] reg_addr,
    input wire pciu_pkg::pciu_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Pins, sampled from the pad whatever their direction.
    input wire logic [7:0] change_inputs_low,
    input wire logic [6:0] change_inputs_mid,
    input wire logic [7:0] change_inputs_high,
    input wire logic ext_irq_zero,
    // CPU core side.
    input wire logic global_irq_enable,
    input wire logic ext0_ack,
    input wire pciu_pkg::pciu_group_t group_ack,
    output logic ext0_request,
    output logic group0_request,
    output logic group1_request,
    output logic group2_request,
    output logic wake_request
);
    import pciu_pkg::*;

    pciu_group_t group_change_enables;
    pciu_group_t group_change_flags;
    pciu_byte_t group0_pin_mask;
    pciu_byte_t group1_pin_mask;
    pciu_byte_t group2_pin_mask;
    pciu_sense_t ext0_sense;
    logic ext0_enable;
    logic ext0_pending_flag;

    logic [22:0] pin_meta;
    logic [22:0] pin_sync;
    logic [22:0] pin_prev;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic [1:0] warm;
    logic primed;

    logic [22:0] pin_toggle;
    pciu_group_t group_hit;
    logic ext0_edge;
    logic wr_flags;
    logic wr_ext_flags;
    logic wr_enables;
    logic wr_mask0;
    logic wr_mask1;
    logic wr_mask2;
    logic wr_sense;
    logic wr_ext_enable;
    logic ext0_low_mode;

    // Next values of the flags and the read data.
    pciu_byte_t flags_kept;
    pciu_group_t next_group_flags;
    logic next_ext0_pending;
    pciu_byte_t next_rdata;

    // Flag clear pattern: written ones clear, written zeros keep.
    function automatic pciu_byte_t w1c(input pciu_byte_t cur, input pciu_byte_t wdat, input logic hit);
        w1c = hit ? (cur & ~wdat) : cur;
    endfunction : w1c

    // Strobe qualified by one register offset.
    function automatic logic reg_hit(input logic strobe, input logic [`PCIU_ADDR_W-1:0] addr,
        input logic [`PCIU_ADDR_W-1:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction : reg_hit

    // Request toward one vector: global enable, local enable, flag, and no ack this cycle.
    function automatic logic vector_req(input logic gie, input logic enable, input logic flag, input logic ack);
        vector_req = gie & enable & flag & ~ack;
    endfunction : vector_req

    // Pin synchronisers: only the second stage is read by the change logic.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {change_inputs_high, change_inputs_mid, change_inputs_low};
            pin_sync <= pin_meta;
        end
    end

    // Ext0 synchroniser; it idles high like a pulled-up pin.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
        end else begin
            ext_meta <= ext_irq_zero;
            ext_sync <= ext_meta;
        end
    end

    // Previous pin levels for change detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    // Previous ext0 level for edge detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_prev <= 1'b1;
        end else begin
            ext_prev <= ext_sync;
        end
    end

    // Detection stays off until the synchronisers and the previous levels all hold
    // sampled pin values, so a pin that is high at reset gives no false change.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            warm <= '0;
            primed <= 1'b0;
        end else begin
            warm <= {warm[0], 1'b1};
            primed <= warm[1];
        end
    end

    // Per-pin toggles gated by masks and group enables.
    always_comb begin
        pin_toggle = primed ? (pin_sync ^ pin_prev) : '0;
        group_hit[0] = group_change_enables[0] & |(pin_toggle[7:0] & group0_pin_mask);
        group_hit[1] = group_change_enables[1]
            & |(pin_toggle[14:8] & group1_pin_mask[6:0]);
        group_hit[2] = group_change_enables[2] & |(pin_toggle[22:15] & group2_pin_mask);
    end

    // Ext0 edge recognition per sense mode; low level is not latched.
    always_comb begin
        ext0_edge = 1'b0;
        if (primed) begin
            unique case (ext0_sense)
                `PCIU_SENSE_LOW: ext0_edge = 1'b0;
                `PCIU_SENSE_ANY: ext0_edge = ext_sync ^ ext_prev;
                `PCIU_SENSE_FALL: ext0_edge = ext_prev & ~ext_sync;
                `PCIU_SENSE_RISE: ext0_edge = ~ext_prev & ext_sync;
            endcase
        end
    end

    // Write strobes, one per register; writes to unmapped offsets match none
    // of them and are dropped.
    assign wr_flags = reg_hit(reg_write, reg_addr, `PCIU_OFS_FLAGS);
    assign wr_ext_flags = reg_hit(reg_write, reg_addr, `PCIU_OFS_EXT_FLAGS);
    assign wr_enables = reg_hit(reg_write, reg_addr, `PCIU_OFS_ENABLES);
    assign wr_mask0 = reg_hit(reg_write, reg_addr, `PCIU_OFS_MASK0);
    assign wr_mask1 = reg_hit(reg_write, reg_addr, `PCIU_OFS_MASK1);
    assign wr_mask2 = reg_hit(reg_write, reg_addr, `PCIU_OFS_MASK2);
    assign wr_sense = reg_hit(reg_write, reg_addr, `PCIU_OFS_SENSE);
    assign wr_ext_enable = reg_hit(reg_write, reg_addr, `PCIU_OFS_EXT_ENABLE);
    assign ext0_low_mode = (ext0_sense == `PCIU_SENSE_LOW);

    // Group enables; the spare bits are never stored, so they
    // always read back as zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group_change_enables <= '0;
        end else if (wr_enables) begin
            group_change_enables <= reg_wdata[2:0] & `PCIU_GROUP_BITS;
        end
    end

    // Group zero pin mask.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group0_pin_mask <= `PCIU_RESET_BYTE;
        end else if (wr_mask0) begin
            group0_pin_mask <= reg_wdata;
        end
    end

    // Group one pin mask; its top bit has no pin behind it and is
    // dropped on write so that it reads as zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group1_pin_mask <= `PCIU_RESET_BYTE;
        end else if (wr_mask1) begin
            group1_pin_mask <= reg_wdata & `PCIU_MASK1_BITS;
        end
    end

    // Group two pin mask.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group2_pin_mask <= `PCIU_RESET_BYTE;
        end else if (wr_mask2) begin
            group2_pin_mask <= reg_wdata;
        end
    end

    // Ext0 sense mode; reset leaves it at low-level sensing, so the
    // pending flag stays clear until software picks an edge mode.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext0_sense <= `PCIU_SENSE_LOW;
        end else if (wr_sense) begin
            ext0_sense <= reg_wdata[1:0] & `PCIU_SENSE_BITS;
        end
    end

    // Ext0 enable.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext0_enable <= 1'b0;
        end else if (wr_ext_enable) begin
            ext0_enable <= reg_wdata[`PCIU_BIT_EXT0];
        end
    end

    // Group flags next value: an ack or a written one clears a flag, but a
    // change seen in the same cycle still sets it, so no event is lost.
    always_comb begin
        flags_kept = w1c({5'h00, group_change_flags}, reg_wdata, wr_flags);
        next_group_flags = (flags_kept[2:0] & ~group_ack) | group_hit;
    end

    // Group flags.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group_change_flags <= '0;
        end else begin
            group_change_flags <= next_group_flags;
        end
    end

    // Ext0 pending next value.
    // Later ifs win: low-level mode over a new edge, a new edge over any clear.
    always_comb begin
        next_ext0_pending = ext0_pending_flag;
        if (wr_ext_flags && reg_wdata[`PCIU_BIT_EXT0]) begin
            next_ext0_pending = 1'b0;
        end
        if (ext0_ack) begin
            next_ext0_pending = 1'b0;
        end
        if (ext0_edge) begin
            next_ext0_pending = 1'b1;
        end
        if (ext0_low_mode) begin
            next_ext0_pending = 1'b0;
        end
    end

    // Ext0 pending flag.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext0_pending_flag <= 1'b0;
        end else begin
            ext0_pending_flag <= next_ext0_pending;
        end
    end

    // Ext0 request: the synchronised pin level in low-level mode, so it lasts
    // as long as the pin is held low; the pending flag in the edge modes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext0_request <= 1'b0;
        end else if (ext0_low_mode) begin
            ext0_request <= global_irq_enable & ext0_enable & ~ext_sync;
        end else begin
            ext0_request <= vector_req(global_irq_enable, ext0_enable, ext0_pending_flag, ext0_ack);
        end
    end

    // Group zero request; an ack in the same cycle drops it at once, so
    // the core never enters the same vector twice for one flag.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group0_request <= 1'b0;
        end else begin
            group0_request <= vector_req(global_irq_enable, group_change_enables[0], group_change_flags[0],
                group_ack[0]);
        end
    end

    // Group one request.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group1_request <= 1'b0;
        end else begin
            group1_request <= vector_req(global_irq_enable, group_change_enables[1], group_change_flags[1],
                group_ack[1]);
        end
    end

    // Group two request.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            group2_request <= 1'b0;
        end else begin
            group2_request <= vector_req(global_irq_enable, group_change_enables[2], group_change_flags[2],
                group_ack[2]);
        end
    end

    // Wake pulse for any enabled, unmasked change; it ignores the global
    // enable because a sleeping core must be woken even with interrupts off.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= |group_hit;
        end
    end

    // Read multiplexer; spare bits and unmapped offsets read as zero, and
    // the data stand only in the cycle after the strobe.
    always_comb begin
        next_rdata = `PCIU_ZERO_BYTE;
        if (reg_read) begin
            unique case (reg_addr)
                `PCIU_OFS_FLAGS: next_rdata = {5'h00, group_change_flags};
                `PCIU_OFS_ENABLES: next_rdata = {5'h00, group_change_enables};
                `PCIU_OFS_MASK0: next_rdata = group0_pin_mask;
                `PCIU_OFS_MASK1: next_rdata = group1_pin_mask;
                `PCIU_OFS_MASK2: next_rdata = group2_pin_mask;
                `PCIU_OFS_SENSE: next_rdata = {6'h00, ext0_sense};
                `PCIU_OFS_EXT_ENABLE: next_rdata = {7'h00, ext0_enable};
                `PCIU_OFS_EXT_FLAGS: next_rdata = {7'h00, ext0_pending_flag};
                default: next_rdata = `PCIU_ZERO_BYTE;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= `PCIU_ZERO_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : pciu_core

`default_nettype wire

// ---- sim/pciu_checker.sv ----
// Port assertions for the pin change interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module pciu_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire pciu_pkg::pciu_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Core side.
    input wire logic global_irq_enable,
    input wire pciu_pkg::pciu_group_t group_ack,
    input wire logic ext0_request,
    input wire logic group0_request,
    input wire logic group1_request,
    input wire logic group2_request,
    input wire logic wake_request
);
    import pciu_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_en_rsv; $past(reg_read) && $past(reg_addr) == 8'h68 |-> reg_rdata[7:3] == 5'h00; endproperty
    a_en_rsv: assert property (p_en_rsv) else $error("enable spare bits set");
    property p_fl_rsv; $past(reg_read) && $past(reg_addr) == 8'h3B |-> reg_rdata[7:3] == 5'h00; endproperty
    a_fl_rsv: assert property (p_fl_rsv) else $error("flag spare bits set");
    property p_m1_rsv; $past(reg_read) && $past(reg_addr) == 8'h6C |-> !reg_rdata[7]; endproperty
    a_m1_rsv: assert property (p_m1_rsv) else $error("mask1 bit 7 set");
    property p_grp_gie; group0_request || group1_request || group2_request |-> $past(global_irq_enable); endproperty
    a_grp_gie: assert property (p_grp_gie) else $error("group request without global enable");
    property p_ext_gie; ext0_request |-> $past(global_irq_enable); endproperty
    a_ext_gie: assert property (p_ext_gie) else $error("ext0 request without global enable");
    property p_ack; group_ack[0] |=> !group0_request; endproperty
    a_ack: assert property (p_ack) else $error("group0 request kept after ack");
    property p_w1c; reg_write && reg_addr == 8'h3B && reg_wdata[2] |-> ##2 !group2_request; endproperty
    a_w1c: assert property (p_w1c) else $error("group2 request kept after clear");
    property p_wake; wake_request |=> !wake_request; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    c_grp2: cover property (group2_request);
    c_ext0: cover property (ext0_request);
    c_wake: cover property (wake_request);
endmodule : pciu_checker
bind pciu_core pciu_checker u_chk (.*);
`default_nettype wire

// ---- sim/pciu_cpu_model.sv ----
// CPU core stand-in that acknowledges interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module pciu_cpu_model (
    // Clock, reset and answer enable.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ack_en,
    // Requests in, one acknowledge pulse per vector out; bit 3 is ext0.
    input wire logic [3:0] req,
    output logic [3:0] ack
);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack <= 4'h0;
        end else begin
            ack <= req & ~ack & {4{ack_en}};
        end
    end
endmodule : pciu_cpu_model
`default_nettype wire

// ---- sim/pciu_core_test.sv ----
// Self-checking bench for the pin change interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module pciu_core_test;
    import pciu_pkg::*;
    logic clk_sys, rst_n, reg_write, reg_read, ext_pin, gie, ack_en;
    logic [7:0] reg_addr;
    pciu_byte_t reg_wdata;
    logic [22:0] pins;
    wire logic [7:0] rdata;
    wire logic [3:0] req, ack;
    wire logic wake;
    int err_total, checked, wake_seen;
    pciu_core DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata), .change_inputs_low(pins[7:0]),
        .change_inputs_mid(pins[14:8]), .change_inputs_high(pins[22:15]), .ext_irq_zero(ext_pin),
        .global_irq_enable(gie), .ext0_ack(ack[3]), .group_ack(ack[2:0]), .ext0_request(req[3]),
        .group0_request(req[0]), .group1_request(req[1]), .group2_request(req[2]), .wake_request(wake));
    pciu_cpu_model u_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .ack_en(ack_en), .req(req), .ack(ack));
    // Counts wake pulses; each edge sees the value launched one edge earlier.
    always @(posedge clk_sys) if (wake === 1'b1) wake_seen++;
    task automatic test_done;
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    // A write when w is high, otherwise a read whose data is compared with d.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk_sys);
        {reg_write, reg_read} <= 2'b00;
        #1;
        if (!w) chk(rdata, d);
    endtask : bus
    task automatic wait_on(input int b, input logic v);
        repeat (20) if (req[b] !== v) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h00, req[b]}, {7'h00, v});
        if (req[b] !== v) test_done();
    endtask : wait_on
    task automatic s_reg;
        for (int i = 0; i < 3; i++) bus(1'b0, 8'(8'h6B + i), 8'h00);
        bus(1'b0, 8'h68, 8'h00);
        bus(1'b1, 8'h68, 8'hFF);
        bus(1'b0, 8'h68, 8'h07);
        bus(1'b1, 8'h6C, 8'hFF);
        bus(1'b0, 8'h6C, 8'h7F);
        bus(1'b1, 8'h70, 8'hFF);
        bus(1'b0, 8'h70, 8'h00);
        bus(1'b1, 8'h3B, 8'hFF);
        bus(1'b0, 8'h3B, 8'h00);
    endtask : s_reg
    task automatic s_grp(input int g);
        logic [7:0] b;
        int p;
        int w0;
        b = 8'(1 << g);
        p = g * 8 - g / 2;
        w0 = wake_seen;
        bus(1'b1, 8'h68, b);
        bus(1'b1, 8'(8'h6B + g), 8'hFF);
        @(posedge clk_sys) pins[p] <= ~pins[p];
        wait_on(g, 1'b1);
        bus(1'b1, 8'h3B, 8'h00);
        bus(1'b0, 8'h3B, b);
        @(posedge clk_sys) ack_en <= 1'b1;
        wait_on(g, 1'b0);
        @(posedge clk_sys) ack_en <= 1'b0;
        bus(1'b0, 8'h3B, 8'h00);
        bus(1'b1, 8'(8'h6B + g), 8'h00);
        @(posedge clk_sys) pins[p] <= ~pins[p];
        repeat (6) @(posedge clk_sys);
        bus(1'b0, 8'h3B, 8'h00);
        bus(1'b1, 8'(8'h6B + g), 8'hFF);
        @(posedge clk_sys);
        gie <= 1'b0;
        pins[p] <= ~pins[p];
        repeat (6) @(posedge clk_sys);
        wait_on(g, 1'b0);
        bus(1'b0, 8'h3B, b);
        bus(1'b1, 8'h3B, b);
        bus(1'b0, 8'h3B, 8'h00);
        chk(8'(wake_seen - w0), 8'h02);
        @(posedge clk_sys) gie <= 1'b1;
    endtask : s_grp
    task automatic s_ext;
        bus(1'b1, 8'h69, 8'h01);
        bus(1'b1, 8'h3D, 8'h01);
        @(posedge clk_sys) ext_pin <= 1'b0;
        wait_on(3, 1'b1);
        bus(1'b0, 8'h3C, 8'h01);
        @(posedge clk_sys) ack_en <= 1'b1;
        wait_on(3, 1'b0);
        @(posedge clk_sys) ack_en <= 1'b0;
        bus(1'b0, 8'h3C, 8'h00);
        bus(1'b1, 8'h69, 8'h00);
        wait_on(3, 1'b1);
        bus(1'b0, 8'h3C, 8'h00);
        @(posedge clk_sys) gie <= 1'b0;
        wait_on(3, 1'b0);
        bus(1'b1, 8'h69, 8'h02);
        @(posedge clk_sys) ext_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        bus(1'b0, 8'h3C, 8'h00);
        @(posedge clk_sys) ext_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        bus(1'b0, 8'h3C, 8'h01);
        bus(1'b1, 8'h3C, 8'h01);
        bus(1'b0, 8'h3C, 8'h00);
        bus(1'b1, 8'h69, 8'h03);
        @(posedge clk_sys) ext_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        bus(1'b0, 8'h3C, 8'h01);
    endtask : s_ext
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, reg_write, reg_read, gie, ack_en, reg_addr, reg_wdata, pins} = '0;
        ext_pin = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        gie <= 1'b1;
        s_reg();
        for (int g = 0; g < 3; g++) s_grp(g);
        s_ext();
        test_done();
    end
endmodule : pciu_core_test
`default_nettype wire
